// ---- logic/rcs_defs.svh ----
// Constants for the reset and clock switch block.
// Assumes mclk is the fast clock of the core.
`ifndef RCS_DEFS_SVH
`define RCS_DEFS_SVH

// Timing in fast-clock periods, and the cycle counts derived from them
`define RCS_EXT_MIN_FC 12
`define RCS_MALF_MAX_FC 24
`define RCS_EXT_MIN_CYC (`RCS_EXT_MIN_FC * 1)
`define RCS_MALF_CYC (`RCS_MALF_FC_TO_CYC)
`define RCS_MALF_FC_TO_CYC (`RCS_MALF_MAX_FC * 1)

// System control two bit positions
`define RCS_FAST_EN_BIT 7
`define RCS_SLOW_EN_BIT 6
`define RCS_CLK_SEL_BIT 5

// Reset values
`define RCS_RESET_VECTOR 16'hFFFE
`define RCS_FAST_EN_RST 1'b1
`define RCS_SLOW_EN_RST 1'b0
`define RCS_CLK_SEL_RST 1'b0

`endif

// ---- logic/rcs_pkg.sv ----
// Types shared by the reset and clock switch block.
// Holds no logic.
package rcs_pkg;
  typedef enum logic [1:0] {
    SINGLE_CLOCK_FAST,
    DUAL_CLOCK_FAST,
    SLOW_RUN_FAST_OSC_ON,
    SLOW_ONLY
  } rcs_mode_t;
endpackage

// ---- logic/rcs_pulse_if.sv ----
// Request and busy pair between the main block and its pulse timer.
// Both ends sit on mclk.
`timescale 1ns/10ps
`default_nettype none
interface rcs_pulse_if;
  logic req;
  logic busy;
  modport src (output req, input busy);
  modport tmr (input req, output busy);
endinterface
`default_nettype wire

// ---- logic/rcs_pulse_timer.sv ----
// Bounded pulse timer for malfunction resets.
// Assumes req is synchronous to mclk.
`timescale 1ns/10ps
`default_nettype none
`include "rcs_defs.svh"
module rcs_pulse_timer #(
  parameter int LEN = `RCS_MALF_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Request side
  rcs_pulse_if.tmr p
);
  logic [5:0] cnt_q;

  // --------------------------------
  // Pulse length
  // --------------------------------
  // bounded malfunction pulse
  // Requests during a pulse are absorbed, which keeps the bound
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= 6'h00;
    end else if (cnt_q != 6'h00) begin
      cnt_q <= cnt_q - 6'h01;
    end else if (p.req) begin
      cnt_q <= 6'(LEN);
    end
  end

  assign p.busy = (cnt_q != 6'h00);

  a_pulse_bound: assert property (@(posedge mclk) disable iff (rst) cnt_q <= 6'(LEN))
    else $error("malfunction pulse counter exceeds its length");
endmodule
`default_nettype wire

// ---- logic/rcs_reset_clock_switch.sv ----
// Reset merge and main clock source switch.
// Assumes mclk is the fast clock, pin inputs are asynchronous, other inputs on mclk.
`timescale 1ns/10ps
`default_nettype none
`include "rcs_defs.svh"

module rcs_reset_clock_switch #(
  parameter logic [15:0] SFR_LO = 16'h0000,
  parameter logic [15:0] SFR_HI = 16'h003F,
  parameter logic [15:0] RAM_LO = 16'h0040,
  parameter logic [15:0] RAM_HI = 16'h083F,
  parameter logic [15:0] DBR_LO = 16'h0F00,
  parameter logic [15:0] DBR_HI = 16'h0FFF
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Pins
  input wire logic resetPinN,
  input wire logic slowClkPin,
  // Control write from the core
  input wire logic ctlWrite,
  input wire logic [7:0] ctlWdata,
  // Fetch watch and trap setup
  input wire logic fetchValid,
  input wire logic [15:0] fetchAddr,
  input wire logic ramTrapEnable,
  input wire logic trapAsReset,
  // Watchdog
  input wire logic watchdogResetReq,
  input wire logic watchdogDisable,
  // Reset results and trap interrupt
  output logic internalReset_q,
  output logic pcLoad_q,
  output logic [15:0] resetVector_q,
  output logic watchdogEnable_q,
  output logic trapIrq_q,
  // Clock control
  output logic fastOscEnable_q,
  output logic slowOscEnable_q,
  output logic mainClockSelect_q,
  output logic runOnSlow_q,
  output rcs_pkg::rcs_mode_t mode_q
);
  logic pinS1_q, pinS2_q, fsS1_q, fsS2_q, fsS3_q;
  logic [4:0] lowCnt_q;
  logic extRst_q;
  logic fsRise, trapHit, clkDis, resetActive;
  logic [5:0] runCnt_q;
  rcs_pulse_if pif ();

  rcs_pulse_timer #(.LEN(`RCS_MALF_CYC)) u_timer (
    .mclk(mclk),
    .rst(rst),
    .p(pif)
  );

  // --------------------------------
  // Pin synchronisers
  // --------------------------------
  // synchronise reset pin
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pinS1_q <= 1'b1;
      pinS2_q <= 1'b1;
      fsS1_q <= 1'b0;
      fsS2_q <= 1'b0;
      fsS3_q <= 1'b0;
    end else begin
      pinS1_q <= resetPinN;
      pinS2_q <= pinS1_q;
      fsS1_q <= slowClkPin;
      fsS2_q <= fsS1_q;
      fsS3_q <= fsS2_q;
    end
  end

  assign fsRise = fsS2_q & ~fsS3_q;

  // --------------------------------
  // External reset
  // --------------------------------
  // low twelve cycles
  // Short glitches on the pin are filtered by the count
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      lowCnt_q <= 5'h00;
      extRst_q <= 1'b0;
    end else begin
      lowCnt_q <= pinS2_q ? 5'h00 :
                  (lowCnt_q == 5'(`RCS_EXT_MIN_CYC) ? lowCnt_q : lowCnt_q + 5'h01);
      extRst_q <= ~pinS2_q & (extRst_q | (lowCnt_q == 5'(`RCS_EXT_MIN_CYC - 1)));
    end
  end

  // --------------------------------
  // Malfunction requests
  // --------------------------------
  // trapped fetch regions
  assign trapHit = fetchValid & ~internalReset_q &
                   (((fetchAddr >= SFR_LO) && (fetchAddr <= SFR_HI)) ||
                    ((fetchAddr >= DBR_LO) && (fetchAddr <= DBR_HI)) ||
                    (ramTrapEnable && (fetchAddr >= RAM_LO) && (fetchAddr <= RAM_HI)));

  assign clkDis = ctlWrite & ~internalReset_q &
                  ((fastOscEnable_q & slowOscEnable_q &
                    ~ctlWdata[`RCS_FAST_EN_BIT] & ~ctlWdata[`RCS_SLOW_EN_BIT]) |
                   (~mainClockSelect_q & fastOscEnable_q & ~ctlWdata[`RCS_FAST_EN_BIT]) |
                   (mainClockSelect_q & slowOscEnable_q & ~ctlWdata[`RCS_SLOW_EN_BIT]));

  assign pif.req = (trapHit & trapAsReset) | watchdogResetReq | clkDis;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      trapIrq_q <= 1'b0;
    end else begin
      trapIrq_q <= trapHit & ~trapAsReset;
    end
  end

  // --------------------------------
  // Internal reset and vector
  // --------------------------------
  // one merged reset
  // timer state is not trusted at power-on, only its bound
  assign resetActive = extRst_q | pif.busy;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      internalReset_q <= 1'b1;
      pcLoad_q <= 1'b0;
      resetVector_q <= `RCS_RESET_VECTOR;
      watchdogEnable_q <= 1'b1;
    end else begin
      internalReset_q <= resetActive;
      pcLoad_q <= internalReset_q & ~resetActive;
      resetVector_q <= `RCS_RESET_VECTOR;
      if (internalReset_q) begin
        watchdogEnable_q <= 1'b1;
      end else if (watchdogDisable) begin
        watchdogEnable_q <= 1'b0;
      end
    end
  end

  // --------------------------------
  // Clock control bits
  // --------------------------------
  // reset forces single fast
  // software orders the steps, hardware only guards them
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      fastOscEnable_q <= `RCS_FAST_EN_RST;
      slowOscEnable_q <= `RCS_SLOW_EN_RST;
      mainClockSelect_q <= `RCS_CLK_SEL_RST;
    end else if (internalReset_q) begin
      fastOscEnable_q <= `RCS_FAST_EN_RST;
      slowOscEnable_q <= `RCS_SLOW_EN_RST;
      mainClockSelect_q <= `RCS_CLK_SEL_RST;
    end else if (ctlWrite && !clkDis) begin
      fastOscEnable_q <= ctlWdata[`RCS_FAST_EN_BIT];
      slowOscEnable_q <= ctlWdata[`RCS_SLOW_EN_BIT];
      mainClockSelect_q <= ctlWdata[`RCS_CLK_SEL_BIT];
    end
  end

  // handover at slow edge
  // Waiting for a slow edge avoids a runt cycle on the core clock
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      runOnSlow_q <= 1'b0;
    end else if (internalReset_q) begin
      runOnSlow_q <= 1'b0;
    end else if (fsRise) begin
      runOnSlow_q <= mainClockSelect_q;
    end
  end

  // fast oscillator may stay on in slow
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_q <= rcs_pkg::SINGLE_CLOCK_FAST;
    end else begin
      case ({mainClockSelect_q, fastOscEnable_q, slowOscEnable_q})
        3'h1, 3'h3: mode_q <= rcs_pkg::DUAL_CLOCK_FAST;
        3'h6, 3'h7: mode_q <= rcs_pkg::SLOW_RUN_FAST_OSC_ON;
        3'h4, 3'h5: mode_q <= rcs_pkg::SLOW_ONLY;
        default: mode_q <= rcs_pkg::SINGLE_CLOCK_FAST;
      endcase
    end
  end

  // --------------------------------
  // Checks
  // --------------------------------
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      runCnt_q <= 6'h00;
    end else begin
      runCnt_q <= (internalReset_q && !extRst_q) ? runCnt_q + 6'h01 : 6'h00;
    end
  end

  a_ext_min_low: assert property (@(posedge mclk) disable iff (rst)
    $rose(extRst_q) |-> $past(lowCnt_q) == 5'(`RCS_EXT_MIN_CYC - 1) && !$past(pinS2_q))
    else $error("external reset taken before minimum low time");
  a_reset_to_fast: assert property (@(posedge mclk) disable iff (rst)
    internalReset_q |=> fastOscEnable_q && !slowOscEnable_q && !mainClockSelect_q && !runOnSlow_q)
    else $error("reset did not restore single clock fast mode");
  a_vector_load: assert property (@(posedge mclk) disable iff (rst)
    $fell(internalReset_q) |-> pcLoad_q && resetVector_q == `RCS_RESET_VECTOR ##1 !pcLoad_q)
    else $error("reset release did not load the top vector once");
  a_malf_length: assert property (@(posedge mclk) disable iff (rst)
    runCnt_q <= 6'(`RCS_MALF_CYC))
    else $error("malfunction reset longer than its bound");
  a_trap_reset: assert property (@(posedge mclk) disable iff (rst)
    trapHit && trapAsReset && !pif.busy |-> ##[1:2] internalReset_q)
    else $error("trapped fetch did not raise reset");
  a_trap_irq: assert property (@(posedge mclk) disable iff (rst)
    trapHit && !trapAsReset |=> trapIrq_q && !pif.busy)
    else $error("trap interrupt not raised");
  a_clkdis_both: assert property (@(posedge mclk) disable iff (rst)
    ctlWrite && !internalReset_q && fastOscEnable_q && slowOscEnable_q &&
    !ctlWdata[`RCS_FAST_EN_BIT] && !ctlWdata[`RCS_SLOW_EN_BIT] |=> pif.busy ##1 internalReset_q)
    else $error("clearing both oscillators did not reset");
  a_clkdis_fast: assert property (@(posedge mclk) disable iff (rst)
    ctlWrite && !internalReset_q && !mainClockSelect_q && fastOscEnable_q &&
    !ctlWdata[`RCS_FAST_EN_BIT] |=> pif.busy)
    else $error("stopping the running fast clock did not reset");
  a_clkdis_slow: assert property (@(posedge mclk) disable iff (rst)
    ctlWrite && !internalReset_q && mainClockSelect_q && slowOscEnable_q &&
    !ctlWdata[`RCS_SLOW_EN_BIT] |=> pif.busy)
    else $error("stopping the running slow clock did not reset");
  a_osc_kept: assert property (@(posedge mclk) disable iff (rst)
    clkDis |=> $stable(fastOscEnable_q) && $stable(slowOscEnable_q))
    else $error("oscillator stopped by a clock-disable write");
  a_slow_handover: assert property (@(posedge mclk) disable iff (rst)
    $changed(runOnSlow_q) && !$past(internalReset_q) |-> $past(fsRise))
    else $error("clock handover not aligned to slow edge");
  a_reset_merge: assert property (@(posedge mclk) disable iff (rst)
    $rose(internalReset_q) |-> $past(extRst_q || pif.busy))
    else $error("internal reset without a source");
  a_wdog_enable: assert property (@(posedge mclk) disable iff (rst)
    internalReset_q |=> watchdogEnable_q)
    else $error("reset did not enable watchdog");
endmodule
`default_nettype wire

// ---- tb/rcs_ext_model.sv ----
// Reset pin and slow oscillator outside the block.
// Assumes mclk from the bench; the pin has a pull-up.
`timescale 1ns/10ps
`default_nettype none
module rcs_ext_model (
  // Clock
  input wire logic mclk,
  // Pins
  output logic resetPinN,
  output logic slowClkPin
);
  int ph = 0;
  initial begin
    resetPinN = 1'b1;
    slowClkPin = 1'b0;
  end
  // Slow oscillator runs free, 16 mclk periods, unrelated to bench steps
  always @(posedge mclk) begin
    ph <= (ph + 1) % 16;
    slowClkPin <= (ph < 8);
  end
  // pin held low for n edges
  task automatic holdLow(input int n);
    @(posedge mclk) resetPinN <= 1'b0;
    repeat (n) @(posedge mclk);
    resetPinN <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Bench for the reset and clock switch block.
// Assumes the external model drives pin and slow clock.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic mclk, rst, resetPinN, slowClkPin, ctlWrite, fetchValid, ramTrapEnable, trapAsReset;
  logic watchdogResetReq, watchdogDisable, internalReset_q, pcLoad_q, watchdogEnable_q, trapIrq_q;
  logic fastOscEnable_q, slowOscEnable_q, mainClockSelect_q, runOnSlow_q;
  logic [7:0] ctlWdata;
  logic [15:0] fetchAddr, resetVector_q, lfsr;
  rcs_pkg::rcs_mode_t mode_q;
  int miscompares = 0;
  int checks_done = 0;
  rcs_reset_clock_switch u_rcs_reset_clock_switch (.mclk(mclk), .rst(rst), .resetPinN(resetPinN),
    .slowClkPin(slowClkPin), .ctlWrite(ctlWrite), .ctlWdata(ctlWdata), .fetchValid(fetchValid),
    .fetchAddr(fetchAddr), .ramTrapEnable(ramTrapEnable), .trapAsReset(trapAsReset),
    .watchdogResetReq(watchdogResetReq), .watchdogDisable(watchdogDisable),
    .internalReset_q(internalReset_q), .pcLoad_q(pcLoad_q), .resetVector_q(resetVector_q),
    .watchdogEnable_q(watchdogEnable_q), .trapIrq_q(trapIrq_q), .fastOscEnable_q(fastOscEnable_q),
    .slowOscEnable_q(slowOscEnable_q), .mainClockSelect_q(mainClockSelect_q),
    .runOnSlow_q(runOnSlow_q), .mode_q(mode_q));
  rcs_ext_model u_rcs_ext_model (.mclk(mclk), .resetPinN(resetPinN), .slowClkPin(slowClkPin));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  function automatic logic [15:0] lfsrNext(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic trapHit(input logic [15:0] a, input logic ramEn);
    return (a <= 16'h003F) || (a >= 16'h0F00) || (ramEn && a >= 16'h0040 && a <= 16'h083F);
  endfunction
  function automatic logic [15:0] bits();
    return {13'h0, fastOscEnable_q, slowOscEnable_q, mainClockSelect_q};
  endfunction
  task automatic wr(input logic [7:0] d);
    @(posedge mclk) ctlWrite <= 1'b1;
    ctlWdata <= d;
    @(posedge mclk) ctlWrite <= 1'b0;
    @(negedge mclk);
  endtask
  task automatic waitSlow(input logic v);
    for (int i = 0; i < 60 && runOnSlow_q !== v; i++) @(negedge mclk);
    @(negedge mclk);
    check("handover", {15'h0, runOnSlow_q}, {15'h0, v});
  endtask
  // Waits out reset, then checks the state it leaves behind
  task automatic relChk();
    for (int i = 0; i < 80 && internalReset_q !== 1'b0; i++) @(negedge mclk);
    check("pcLoad", {15'h0, pcLoad_q}, 16'h1);
    check("vector", resetVector_q, 16'hFFFE);
    check("wdEnable", {15'h0, watchdogEnable_q}, 16'h1);
    check("ctlBits", bits(), 16'h4);
    check("mode", {14'h0, mode_q}, {14'h0, rcs_pkg::SINGLE_CLOCK_FAST});
    check("onSlow", {15'h0, runOnSlow_q}, 16'h0);
  endtask
  task automatic malf(input string what);
    int n;
    n = 0;
    for (int i = 0; i < 6 && internalReset_q !== 1'b1; i++) @(negedge mclk);
    while (internalReset_q === 1'b1 && n < 40) begin
      n++;
      @(negedge mclk);
    end
    check(what, 16'(n), 16'h18);
    relChk();
  endtask
  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    finish_test();
  end
  initial begin
    logic [15:0] sv;
    {rst, ctlWrite, fetchValid, ramTrapEnable, trapAsReset, watchdogResetReq, watchdogDisable} = 7'h40;
    ctlWdata = 8'h00;
    fetchAddr = 16'h0000;
    lfsr = 16'hAE36;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    @(negedge mclk);
    relChk();
    // Slow entry, slow only, and back to fast
    wr(8'hE0);
    check("selSlow", bits(), 16'h7);
    waitSlow(1'b1);
    check("mode2", {14'h0, mode_q}, {14'h0, rcs_pkg::SLOW_RUN_FAST_OSC_ON});
    wr(8'h60);
    @(negedge mclk);
    check("mode1", {14'h0, mode_q}, {14'h0, rcs_pkg::SLOW_ONLY});
    wr(8'hE0);
    repeat (10) @(negedge mclk);
    wr(8'hC0);
    check("stillSlow", {15'h0, runOnSlow_q}, 16'h1);
    waitSlow(1'b0);
    check("modeF", {14'h0, mode_q}, {14'h0, rcs_pkg::DUAL_CLOCK_FAST});
    // Pin reset ends slow running; a short low is ignored
    wr(8'hE0);
    waitSlow(1'b1);
    u_rcs_ext_model.holdLow(11);
    repeat (6) @(negedge mclk);
    check("shortLow", {15'h0, internalReset_q}, 16'h0);
    u_rcs_ext_model.holdLow(20);
    @(negedge mclk);
    check("pinRst", {15'h0, internalReset_q}, 16'h1);
    relChk();
    // Clock-disable writes leave the bits and reset instead
    for (int k = 0; k < 3; k++) begin
      wr(k == 2 ? 8'hE0 : 8'hC0);
      sv = bits();
      wr(k == 0 ? 8'h00 : (k == 1 ? 8'h40 : 8'hA0));
      check("heldBits", bits(), sv);
      malf("clkRst");
    end
    // Random fetches answered as interrupt
    repeat (60) begin
      lfsr = lfsrNext(lfsr);
      @(posedge mclk) fetchValid <= 1'b1;
      fetchAddr <= {4'h0, lfsr[11:0]};
      ramTrapEnable <= lfsr[12];
      @(posedge mclk) fetchValid <= 1'b0;
      @(negedge mclk);
      check("trapIrq", {15'h0, trapIrq_q}, {15'h0, trapHit(fetchAddr, ramTrapEnable)});
    end
    @(posedge mclk) trapAsReset <= 1'b1;
    fetchValid <= 1'b1;
    fetchAddr <= 16'h0F10;
    @(posedge mclk) fetchValid <= 1'b0;
    @(negedge mclk);
    malf("trapRst");
    @(posedge mclk) watchdogDisable <= 1'b1;
    @(posedge mclk) watchdogDisable <= 1'b0;
    @(negedge mclk);
    check("wdOff", {15'h0, watchdogEnable_q}, 16'h0);
    // Back to back requests are absorbed into one pulse
    @(posedge mclk) watchdogResetReq <= 1'b1;
    repeat (2) @(posedge mclk);
    watchdogResetReq <= 1'b0;
    @(negedge mclk);
    malf("wdRst");
    finish_test();
  end
endmodule
`default_nettype wire
